// file: udi_pkg.sv
package udi_pkg;

  localparam int UDI_ADDR_W = 12;
  localparam int UDI_IDX_W = 10;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] UDI_IDX_DATA = 10'h0C0;
  localparam logic [9:0] UDI_IDX_IER = 10'h0C1;
  localparam logic [9:0] UDI_IDX_CFG = 10'h0C8;
  localparam logic [9:0] UDI_IDX_STS = 10'h0C9;
  localparam logic [9:0] UDI_IDX_MASK = 10'h0CA;
  localparam logic [9:0] UDI_IDX_SRC = 10'h0CB;

  localparam logic [7:0] UDI_IER_RST = 8'h00;
  localparam int UDI_IER_W = 5;
  localparam int UDI_IER_RX = 0;
  localparam int UDI_IER_TXE = 1;
  localparam int UDI_IER_LINE = 2;
  localparam int UDI_IER_MODEM = 3;
  localparam int UDI_IER_TXC = 4;

  localparam logic [15:0] UDI_DIV_RST = 16'h0002;

  localparam int UDI_CFG_FIFO = 0;
  localparam int UDI_CFG_LEN_LO = 1;
  localparam int UDI_CFG_DLAB = 7;
  localparam logic [7:0] UDI_CFG_RST = 8'h00;

  // Status bits, highest priority first.
  localparam int UDI_NSRC = 6;
  localparam int UDI_S_LINE = 0;
  localparam int UDI_S_RXRDY = 1;
  localparam int UDI_S_TOUT = 2;
  localparam int UDI_S_TXC = 3;
  localparam int UDI_S_TXE = 4;
  localparam int UDI_S_MODEM = 5;
  localparam logic [5:0] UDI_MASK_RST = 6'h3F;

  localparam logic [2:0] UDI_CODE_LINE = 3'h3;
  localparam logic [2:0] UDI_CODE_RXRDY = 3'h2;
  localparam logic [2:0] UDI_CODE_TOUT = 3'h6;
  localparam logic [2:0] UDI_CODE_TXC = 3'h5;
  localparam logic [2:0] UDI_CODE_TXE = 3'h1;
  localparam logic [2:0] UDI_CODE_MODEM = 3'h0;

  localparam int UDI_TX_DEPTH = 16;
  localparam int UDI_RX_DEPTH = 16;

  localparam logic [1:0] UDI_RESP_OKAY = 2'h0;
  localparam logic [1:0] UDI_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [UDI_ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [UDI_ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } udi_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } udi_axi_rsp_t;

  typedef struct packed {
    logic fifoEnable;
    logic [1:0] charLen;
    logic divisorAccess;
  } udi_line_t;

  typedef enum logic [2:0] {
    UDI_W_IDLE = 3'b001,
    UDI_W_DO = 3'b010,
    UDI_W_RESP = 3'b100
  } udi_wstate_t;

endpackage

// file: udi_fifo.sv
`timescale 1ns/100ps
module udi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic single,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH+1)-1:0] count
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] ONE = CW'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic push;
  logic pop;

  // With the queue disabled the store behaves as one holding byte.
  assign inReady = count < (single ? ONE : FULL);
  assign outValid = count != '0;
  assign outData = mem[rdPtr];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wrPtr <= (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + PW'(1);
      end
      if (pop)
      begin
        rdPtr <= (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + PW'(1);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end
endmodule // udi_fifo

// file: udi_prio.sv
`timescale 1ns/100ps
module udi_prio (
  input wire logic [udi_pkg::UDI_NSRC-1:0] pending,
  output logic [2:0] code,
  output logic none
);
  import udi_pkg::*;

  always_comb
  begin
    none = 1'b0;
    if (pending[UDI_S_LINE])
      code = UDI_CODE_LINE;
    else if (pending[UDI_S_RXRDY])
      code = UDI_CODE_RXRDY;
    else if (pending[UDI_S_TOUT])
      code = UDI_CODE_TOUT;
    else if (pending[UDI_S_TXC])
      code = UDI_CODE_TXC;
    else if (pending[UDI_S_TXE])
      code = UDI_CODE_TXE;
    else if (pending[UDI_S_MODEM])
      code = UDI_CODE_MODEM;
    else
    begin
      code = 3'h0;
      none = 1'b1;
    end
  end
endmodule // udi_prio

// file: udi_uart_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Reset returns every register to default.
// - Unused registers and bits: ignore writes, read zero.
// - Short characters send only low bits.
// - Data writes queue sixteen bytes, else one.
// - Data reads pop receive queue or holder.
// - Short received characters zero upper bits.
// - Transmit and receive share offset C0.
// - Enable register at C1, resets zero.
// - Enable bit 4: transmission complete interrupt.
// - Enable bit 3: modem edge interrupt.
// - Enable bit 2: line status errors interrupt.
// - Enable bit 1: transmit empty interrupt.
// - Enable bit 0: receive ready and timeout.
// - Divisor access bit maps divisor bytes instead.
// - Report only highest priority pending source.
module udi_uart_regs #(
  parameter int TX_DEPTH = udi_pkg::UDI_TX_DEPTH,
  parameter int RX_DEPTH = udi_pkg::UDI_RX_DEPTH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire udi_pkg::udi_axi_req_t axiReq,
  output udi_pkg::udi_axi_rsp_t axiRsp,
  output logic txValid,
  input wire logic txReady,
  output logic [7:0] txData,
  input wire logic txShiftEmpty,
  input wire logic rxValid,
  output logic rxReady,
  input wire logic [7:0] rxData,
  input wire logic rxTimeout,
  input wire logic lineError,
  input wire logic modemEdge,
  output udi_pkg::udi_line_t lineCfg,
  output logic [15:0] divisor,
  output logic divisorLoad,
  output logic irqOut
);
  import udi_pkg::*;

  localparam int TCW = $clog2(TX_DEPTH + 1);
  localparam int RCW = $clog2(RX_DEPTH + 1);

  udi_wstate_t wState;
  logic [UDI_ADDR_W-1:0] awAddr;
  logic awHeld;
  logic [7:0] wByte;
  logic wLane0;
  logic [3:0] wLanes;
  logic wHeld;
  logic [UDI_IDX_W-1:0] wIdx;
  logic [UDI_IDX_W-1:0] rIdx;
  logic wrFire;
  logic rdFire;
  logic wrHit;
  logic rdHit;
  logic [7:0] rdByte;

  logic [UDI_IER_W-1:0] irqEnable;
  logic [7:0] cfgReg;
  logic [UDI_NSRC-1:0] irqStatus;
  logic [UDI_NSRC-1:0] irqMask;
  logic [UDI_NSRC-1:0] srcActive;
  logic [2:0] srcCode;
  logic srcNone;

  logic [7:0] charMask;
  logic txPush;
  logic txInReady;
  logic txOutValid;
  logic [7:0] txRaw;
  logic [TCW-1:0] txCount;
  logic rxOutValid;
  logic rxPop;
  logic [7:0] rxHead;
  logic [RCW-1:0] rxCount;
  logic txEmpty;

  assign lineCfg.fifoEnable = cfgReg[UDI_CFG_FIFO];
  assign lineCfg.charLen = cfgReg[UDI_CFG_LEN_LO +: 2];
  assign lineCfg.divisorAccess = cfgReg[UDI_CFG_DLAB];

  // A 5-bit character keeps bits 4:0, an 8-bit one all eight.
  assign charMask = 8'hFF >> (2'h3 - lineCfg.charLen);

  // Write channel: address and data are taken in either order.
  assign axiRsp.awready = !awHeld && (wState == UDI_W_IDLE);
  assign axiRsp.wready = !wHeld && (wState == UDI_W_IDLE);
  assign axiRsp.bvalid = wState == UDI_W_RESP;
  assign wIdx = awAddr[UDI_ADDR_W-1:2];
  assign wrFire = wState == UDI_W_DO;
  assign wLane0 = wLanes[0];

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      awHeld <= 1'b0;
      awAddr <= '0;
    end
    else if (axiReq.awvalid && axiRsp.awready)
    begin
      awHeld <= 1'b1;
      awAddr <= axiReq.awaddr;
    end
    else if (wrFire)
    begin
      awHeld <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wHeld <= 1'b0;
      wByte <= 8'h00;
      wLanes <= 4'h0;
    end
    else if (axiReq.wvalid && axiRsp.wready)
    begin
      wHeld <= 1'b1;
      wByte <= axiReq.wdata[7:0];
      wLanes <= axiReq.wstrb;
    end
    else if (wrFire)
    begin
      wHeld <= 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      wState <= UDI_W_IDLE;
    end
    else
    begin
      unique case (wState)
        UDI_W_IDLE:
          if (awHeld && wHeld)
            wState <= UDI_W_DO;
        UDI_W_DO:
          wState <= UDI_W_RESP;
        UDI_W_RESP:
          if (axiReq.bready)
            wState <= UDI_W_IDLE;
      endcase
    end
  end

  always_comb
  begin
    unique case (wIdx)
      UDI_IDX_DATA, UDI_IDX_IER, UDI_IDX_CFG,
      UDI_IDX_STS, UDI_IDX_MASK, UDI_IDX_SRC:
        wrHit = 1'b1;
      default:
        wrHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      axiRsp.bresp <= UDI_RESP_OKAY;
    else if (wrFire)
      axiRsp.bresp <= wrHit ? UDI_RESP_OKAY : UDI_RESP_SLVERR;
  end

  // Enable register; bits 7:5 are not stored.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      irqEnable <= UDI_IER_RST[UDI_IER_W-1:0];
    else if (wrFire && wLane0 && wIdx == UDI_IDX_IER
      && !lineCfg.divisorAccess)
      irqEnable <= wByte[UDI_IER_W-1:0];
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      cfgReg <= UDI_CFG_RST;
    else if (wrFire && wLane0 && wIdx == UDI_IDX_CFG)
      cfgReg <= wByte & 8'h87;
  end

  // Divisor bytes take the shared slots while access is set.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      divisor <= UDI_DIV_RST;
      divisorLoad <= 1'b0;
    end
    else
    begin
      divisorLoad <= 1'b0;
      if (wrFire && wLane0 && lineCfg.divisorAccess)
      begin
        if (wIdx == UDI_IDX_DATA)
        begin
          divisor[7:0] <= wByte;
          divisorLoad <= 1'b1;
        end
        else if (wIdx == UDI_IDX_IER)
        begin
          divisor[15:8] <= wByte;
          divisorLoad <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
      irqMask <= UDI_MASK_RST;
    else if (wrFire && wLane0 && wIdx == UDI_IDX_MASK)
      irqMask <= wByte[UDI_NSRC-1:0];
  end

  // A byte written to a full queue is dropped.
  assign txPush = wrFire && wLane0 && wIdx == UDI_IDX_DATA
    && !lineCfg.divisorAccess;

  udi_fifo #(
    .WIDTH(8),
    .DEPTH(TX_DEPTH)
  ) txQueue (
    .mclk(mclk),
    .nrst(nrst),
    .single(!lineCfg.fifoEnable),
    .inValid(txPush),
    .inReady(txInReady),
    .inData(wByte),
    .outValid(txOutValid),
    .outReady(txReady),
    .outData(txRaw),
    .count(txCount)
  );

  assign txValid = txOutValid;
  assign txData = txRaw & charMask;

  udi_fifo #(
    .WIDTH(8),
    .DEPTH(RX_DEPTH)
  ) rxQueue (
    .mclk(mclk),
    .nrst(nrst),
    .single(!lineCfg.fifoEnable),
    .inValid(rxValid),
    .inReady(rxReady),
    .inData(rxData & charMask),
    .outValid(rxOutValid),
    .outReady(rxPop),
    .outData(rxHead),
    .count(rxCount)
  );

  // Read channel: one read under way; data registered at acceptance.
  assign axiRsp.arready = !axiRsp.rvalid;
  assign rdFire = axiReq.arvalid && axiRsp.arready;
  assign rIdx = axiReq.araddr[UDI_ADDR_W-1:2];
  assign rxPop = rdFire && rIdx == UDI_IDX_DATA
    && !lineCfg.divisorAccess;

  always_comb
  begin
    rdHit = 1'b1;
    rdByte = 8'h00;
    unique case (rIdx)
      UDI_IDX_DATA:
        if (lineCfg.divisorAccess)
          rdByte = divisor[7:0];
        else if (rxOutValid)
          rdByte = rxHead;
      UDI_IDX_IER:
        if (lineCfg.divisorAccess)
          rdByte = divisor[15:8];
        else
          rdByte = {3'h0, irqEnable};
      UDI_IDX_CFG:
        rdByte = cfgReg;
      UDI_IDX_STS:
        rdByte = {2'h0, irqStatus};
      UDI_IDX_MASK:
        rdByte = {2'h0, irqMask};
      UDI_IDX_SRC:
        rdByte = {4'h0, srcCode, srcNone};
      default:
        rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      axiRsp.rvalid <= 1'b0;
      axiRsp.rdata <= 32'h0000_0000;
      axiRsp.rresp <= UDI_RESP_OKAY;
    end
    else if (rdFire)
    begin
      axiRsp.rvalid <= 1'b1;
      axiRsp.rdata <= {24'h00_0000, rdByte};
      axiRsp.rresp <= rdHit ? UDI_RESP_OKAY : UDI_RESP_SLVERR;
    end
    else if (axiReq.rready)
    begin
      axiRsp.rvalid <= 1'b0;
    end
  end

  // Interrupt sources, each gated by its enable bit.
  assign txEmpty = !txOutValid;
  assign srcActive[UDI_S_LINE] = lineError
    && irqEnable[UDI_IER_LINE];
  assign srcActive[UDI_S_RXRDY] = rxOutValid
    && irqEnable[UDI_IER_RX];
  assign srcActive[UDI_S_TOUT] = rxTimeout
    && irqEnable[UDI_IER_RX];
  assign srcActive[UDI_S_TXC] = txEmpty && txShiftEmpty
    && irqEnable[UDI_IER_TXC];
  assign srcActive[UDI_S_TXE] = txEmpty
    && irqEnable[UDI_IER_TXE];
  assign srcActive[UDI_S_MODEM] = modemEdge
    && irqEnable[UDI_IER_MODEM];

  udi_prio srcPrio (
    .pending(srcActive),
    .code(srcCode),
    .none(srcNone)
  );

  // Sticky status, write one to clear; a new event wins the cycle.
  always_ff @(posedge mclk)
  begin
    if (!nrst)
      irqStatus <= '0;
    else if (wrFire && wLane0 && wIdx == UDI_IDX_STS)
      irqStatus <= (irqStatus & ~wByte[UDI_NSRC-1:0]) | srcActive;
    else
      irqStatus <= irqStatus | srcActive;
  end

  assign irqOut = |(irqStatus & irqMask);

endmodule // udi_uart_regs

// file: udi_uart_regs_properties.sv
`timescale 1ns/100ps
module udi_chk #(
  parameter int TX_DEPTH = 16,
  parameter int RX_DEPTH = 16
) (
  input logic mclk,
  input logic nrst,
  input udi_pkg::udi_axi_req_t axiReq,
  input udi_pkg::udi_axi_rsp_t axiRsp,
  input logic txValid,
  input logic [7:0] txData,
  input logic rxValid,
  input logic rxReady,
  input udi_pkg::udi_line_t lineCfg,
  input logic [15:0] divisor,
  input logic divisorLoad,
  input logic irqOut
);
  import udi_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  property p_reset;
    $rose(nrst) |-> divisor == UDI_DIV_RST && !irqOut && !txValid;
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset state wrong");
  property p_txMask;
    txValid |-> (txData & ~(8'hFF >> (2'h3 - lineCfg.charLen))) == 8'h00;
  endproperty
  a_txMask: assert property (p_txMask)
    else $error("transmit byte not masked");
  property p_rxSingle;
    !lineCfg.fifoEnable && rxValid && rxReady && !axiReq.arvalid
      |=> !rxReady || lineCfg.fifoEnable;
  endproperty
  a_rxSingle: assert property (p_rxSingle)
    else $error("single holder took a second byte");
  property p_wrLat;
    axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
      |-> ##3 axiRsp.bvalid;
  endproperty
  a_wrLat: assert property (p_wrLat)
    else $error("write response late");
  property p_rdLat;
    axiReq.arvalid && axiRsp.arready
      |=> axiRsp.rvalid && axiRsp.rdata[31:8] == 24'h0;
  endproperty
  a_rdLat: assert property (p_rdLat)
    else $error("read answer late or upper bits set");
  property p_wrBusy;
    axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready;
  endproperty
  a_wrBusy: assert property (p_wrBusy)
    else $error("write accepted while responding");
  property p_rdBusy;
    axiRsp.rvalid |-> !axiRsp.arready;
  endproperty
  a_rdBusy: assert property (p_rdBusy)
    else $error("read accepted while answering");
  property p_divLoad;
    divisorLoad |-> lineCfg.divisorAccess ##1 !divisorLoad;
  endproperty
  a_divLoad: assert property (p_divLoad)
    else $error("divisor load without access");
  property p_divChange;
    $changed(divisor) |-> divisorLoad;
  endproperty
  a_divChange: assert property (p_divChange)
    else $error("divisor changed without a load pulse");
endmodule // udi_chk
bind udi_uart_regs udi_chk #(.TX_DEPTH(TX_DEPTH), .RX_DEPTH(RX_DEPTH)) chk_u (
  .mclk(mclk), .nrst(nrst), .axiReq(axiReq), .axiRsp(axiRsp),
  .txValid(txValid), .txData(txData), .rxValid(rxValid),
  .rxReady(rxReady), .lineCfg(lineCfg), .divisor(divisor),
  .divisorLoad(divisorLoad), .irqOut(irqOut));

// file: udi_peer.sv
`timescale 1ns/100ps
module udi_peer (
  input logic mclk,
  input logic nrst,
  input logic hold,
  input logic txValid,
  input logic [7:0] txData,
  output logic txReady,
  output logic txShiftEmpty,
  output logic rxValid,
  input logic rxReady,
  output logic [7:0] rxData
);
  logic [7:0] got[$];
  logic [7:0] sendQ[$];
  logic idleBit = 1'b0;
  int busy = 0;
  // A taken byte keeps the shifter busy for four cycles.
  assign txReady = !hold && busy == 0;
  assign txShiftEmpty = busy == 0;
  always @(posedge mclk)
  begin
    idleBit <= ~idleBit;
    if (!nrst)
      busy <= 0;
    else if (txValid && txReady)
    begin
      got.push_back(txData);
      busy <= 4;
    end
    else if (busy > 0)
      busy <= busy - 1;
  end
  // An idle line toggles so that a stale byte is never mistaken for data.
  always @(posedge mclk)
  begin
    if (rxValid && rxReady)
      void'(sendQ.pop_front());
    rxValid <= nrst && sendQ.size() != 0;
    rxData <= sendQ.size() != 0 ? sendQ[0] : {8{idleBit}};
  end
endmodule // udi_peer

// file: test_uart_data_and_irq_enable_regs.sv
`timescale 1ns/100ps
module test_uart_data_and_irq_enable_regs;
  import udi_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic hold = 1'b0;
  logic rxTimeout = 1'b0;
  logic lineError = 1'b0;
  logic modemEdge = 1'b0;
  udi_axi_req_t req = '{bready: 1'b1, rready: 1'b1, default: '0};
  udi_axi_rsp_t rsp;
  udi_line_t lineCfg;
  logic txValid, txReady, txShiftEmpty, rxValid, rxReady;
  logic divisorLoad, irqOut;
  logic [7:0] txData, rxData;
  logic [15:0] divisor;
  int nErrors = 0;
  int compares = 0;
  int cyc = 0;
  always #4 mclk = ~mclk;
  udi_uart_regs dut_u (.mclk(mclk), .nrst(nrst), .axiReq(req),
    .axiRsp(rsp), .txValid(txValid), .txReady(txReady), .txData(txData),
    .txShiftEmpty(txShiftEmpty), .rxValid(rxValid), .rxReady(rxReady),
    .rxData(rxData), .rxTimeout(rxTimeout), .lineError(lineError),
    .modemEdge(modemEdge), .lineCfg(lineCfg), .divisor(divisor),
    .divisorLoad(divisorLoad), .irqOut(irqOut));
  udi_peer peer_u (.mclk(mclk), .nrst(nrst), .hold(hold),
    .txValid(txValid), .txData(txData), .txReady(txReady),
    .txShiftEmpty(txShiftEmpty), .rxValid(rxValid), .rxReady(rxReady),
    .rxData(rxData));
  task testDone();
    $display("errors %0d compares %0d", nErrors, compares);
    if (nErrors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      nErrors++;
      testDone();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      nErrors++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d,
      input logic [1:0] s = UDI_RESP_OKAY);
    int t = 0;
    req.awaddr <= {i, 2'h0};
    req.wdata <= {24'h0, d};
    req.wstrb <= 4'h1;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (rsp.awready)
        req.awvalid <= 1'b0;
      if (rsp.wready)
        req.wvalid <= 1'b0;
      t++;
    end
    while (!rsp.bvalid && t < 40);
    chk(32'(rsp.bresp), 32'(s));
  endtask
  task automatic rd(input logic [9:0] i, input logic [31:0] e,
      input logic [1:0] s = UDI_RESP_OKAY);
    int t = 0;
    req.araddr <= {i, 2'h0};
    req.arvalid <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (rsp.arready)
        req.arvalid <= 1'b0;
      t++;
    end
    while (!rsp.rvalid && t < 40);
    chk(rsp.rdata, e);
    chk(32'(rsp.rresp), 32'(s));
  endtask
  task automatic drain(input int n);
    for (int t = 0; t < 300 && peer_u.got.size() < n; t++)
      @(posedge mclk);
    repeat (20) @(posedge mclk);
    chk(32'(peer_u.got.size()), 32'(n));
  endtask
  task automatic settle(input int n);
    for (int t = 0; t < 50 && peer_u.sendQ.size() > n; t++)
      @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask
  task scReset();
    chk(32'(divisor), 32'h2);
    chk(32'(irqOut), 32'h0);
    rd(UDI_IDX_IER, 32'h0);
    rd(UDI_IDX_CFG, 32'h0);
    rd(UDI_IDX_MASK, 32'h3F);
  endtask
  task scRegs();
    rd(10'h0C3, 32'h0, UDI_RESP_SLVERR);
    wr(10'h0C3, 8'h55, UDI_RESP_SLVERR);
    wr(UDI_IDX_IER, 8'h1F);
    rd(UDI_IDX_IER, 32'h1F);
    chk(32'(irqOut), 32'h1);
    wr(UDI_IDX_IER, 8'h00);
    wr(UDI_IDX_STS, 8'h18);
    chk(32'(irqOut), 32'h0);
  endtask
  task scTx();
    hold <= 1'b1;
    wr(UDI_IDX_CFG, 8'h07);
    for (int k = 0; k < 17; k++)
      wr(UDI_IDX_DATA, 8'(8'h30 + k));
    hold <= 1'b0;
    drain(16);
    for (int k = 0; k < 16; k++)
      chk(32'(peer_u.got[k]), 32'(8'h30 + k));
    wr(UDI_IDX_CFG, 8'h01);
    wr(UDI_IDX_DATA, 8'hFF);
    drain(17);
    chk(32'(peer_u.got[16]), 32'h1F);
    hold <= 1'b1;
    wr(UDI_IDX_CFG, 8'h06);
    wr(UDI_IDX_DATA, 8'hA5);
    wr(UDI_IDX_DATA, 8'h5A);
    hold <= 1'b0;
    drain(18);
    chk(32'(peer_u.got[17]), 32'hA5);
  endtask
  task scRx();
    wr(UDI_IDX_CFG, 8'h03);
    peer_u.sendQ.push_back(8'hFF);
    peer_u.sendQ.push_back(8'hC5);
    settle(0);
    rd(UDI_IDX_DATA, 32'h3F);
    rd(UDI_IDX_DATA, 32'h05);
    rd(UDI_IDX_DATA, 32'h00);
    wr(UDI_IDX_CFG, 8'h06);
    peer_u.sendQ.push_back(8'h11);
    peer_u.sendQ.push_back(8'h22);
    settle(1);
    chk(32'(rxReady), 32'h0);
    rd(UDI_IDX_DATA, 32'h11);
    settle(0);
    rd(UDI_IDX_DATA, 32'h22);
  endtask
  task automatic scIrq();
    logic [7:0] stsExp [5] = '{8'h04, 8'h10, 8'h01, 8'h20, 8'h08};
    logic [7:0] codeExp [5] = '{8'h0C, 8'h02, 8'h06, 8'h00, 8'h0A};
    for (int i = 0; i < 5; i++)
    begin
      rxTimeout <= i == 0;
      lineError <= i == 2;
      modemEdge <= i == 3;
      rd(UDI_IDX_STS, 32'h0);
      wr(UDI_IDX_IER, 8'(1 << i));
      rd(UDI_IDX_SRC, 32'(codeExp[i]));
      rd(UDI_IDX_STS, 32'(stsExp[i]));
      chk(32'(irqOut), 32'h1);
      wr(UDI_IDX_MASK, 8'h00);
      chk(32'(irqOut), 32'h0);
      wr(UDI_IDX_MASK, 8'h3F);
      rxTimeout <= 1'b0;
      lineError <= 1'b0;
      modemEdge <= 1'b0;
      wr(UDI_IDX_IER, 8'h00);
      wr(UDI_IDX_STS, stsExp[i]);
      chk(32'(irqOut), 32'h0);
    end
    wr(UDI_IDX_IER, 8'h1F);
    rxTimeout <= 1'b1;
    lineError <= 1'b1;
    rd(UDI_IDX_SRC, 32'h06);
    lineError <= 1'b0;
    rd(UDI_IDX_SRC, 32'h0C);
    rxTimeout <= 1'b0;
    rd(UDI_IDX_SRC, 32'h0A);
    wr(UDI_IDX_IER, 8'h00);
    wr(UDI_IDX_STS, 8'h3F);
    chk(32'(irqOut), 32'h0);
  endtask
  task scDiv();
    wr(UDI_IDX_CFG, 8'h80);
    chk(32'(lineCfg), 32'h1);
    wr(UDI_IDX_DATA, 8'h34);
    chk(32'(divisorLoad), 32'h1);
    wr(UDI_IDX_IER, 8'h12);
    rd(UDI_IDX_DATA, 32'h34);
    chk(32'(divisor), 32'h1234);
    wr(UDI_IDX_CFG, 8'h00);
    rd(UDI_IDX_IER, 32'h0);
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    scReset();
    scRegs();
    scTx();
    scRx();
    scIrq();
    scDiv();
    nrst <= 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    scReset();
    testDone();
  end
endmodule // test_uart_data_and_irq_enable_regs
